// ==== include/pmsc_map.svh ====
`ifndef PMSC_MAP_SVH
`define PMSC_MAP_SVH

// ************************************************
// device register addresses (5-bit)
// ************************************************
`define PMSC_REG_CTRL 5'h00
`define PMSC_REG_BCAST 5'h16
`define PMSC_REG_MAIN 5'h17
`define PMSC_GREG_SDS 5'h12
`define PMSC_GREG_MAC 5'h13

// ************************************************
// field positions and values
// ************************************************
`define PMSC_CTRL_SRST 15
`define PMSC_CTRL_ANEG 12
`define PMSC_BCAST_BIT 0
`define PMSC_MAIN_HX 12
`define PMSC_MAIN_MED_LO 8
`define PMSC_MED_1000X 3'h2
`define PMSC_MAC_LO 14
`define PMSC_MAC_SGMII 2'h0
`define PMSC_MAC_QSGMII 2'h1
`define PMSC_SDS_SGMII 16'h80F0
`define PMSC_SDS_QSGMII 16'h80E0
`define PMSC_SDS_MEDIA 16'h8FC1
`define PMSC_SDS_MATCH 16'hF0FF
`define PMSC_SDS_PMASK 16'h0F00
`define PMSC_SDS_MASK_LO 8

// ************************************************
// reset values
// ************************************************
`define PMSC_CTRL_RST 16'h0000
`define PMSC_MAIN_RST 16'h0000
`define PMSC_MAC_RST 16'h0000
`define PMSC_SDS_RST 16'h0000

// ************************************************
// controller avalon map (byte addresses)
// ************************************************
`define PMSC_AV_ADDR 5'h00
`define PMSC_AV_WDATA 5'h04
`define PMSC_AV_CMD 5'h08
`define PMSC_AV_STAT 5'h0C
`define PMSC_AV_SETUP 5'h10
`define PMSC_SU_QSG 0
`define PMSC_SU_FIB 1
`define PMSC_SU_MASK_LO 8
`define PMSC_SU_GO 31

`endif

// ==== include/pmsc_pkg.sv ====
package pmsc_pkg;

	typedef enum {H_IDLE, H_REQ} pmsc_hst_t;

	typedef enum {SQ_NONE, SQ_MAC, SQ_SDS, SQ_MAIN, SQ_CTRL, SQ_MEDIA} pmsc_step_t;

	typedef struct packed {
		logic we;
		logic glob;
		logic [7:0] port;
		logic [4:0] addr;
		logic [15:0] data;
	} pmsc_op_t;

endpackage

// ==== include/pmsc_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface pmsc_link_if #(parameter int PW = 1);
	logic req;
	logic we;
	logic glob;
	logic [PW-1:0] port;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;

	modport dev (input req, input we, input glob, input port, input addr, input wdata, output rdata, output ack);
	modport ctl (output req, output we, output glob, output port, output addr, output wdata, input rdata, input ack);
endinterface

`default_nettype wire

// ==== hw/pmsc_dev.sv ====
// Notes on behaviour
// - all ports share one host protocol
// - mac mode 00 selects sgmii host
// - mac mode 01 selects qsgmii host
// - host clears main bit 12
// - sgmii setup loads serdes word 0x80F0
// - qsgmii setup loads serdes word 0x80E0
// - main bits 10:8 = 010 selects 1000x fibre
// - control bit 12 enables autonegotiation
// - host writes 0x8FC1 for fibre serdes; the controller puts the setup port mask in bits 11:8 instead of 0xF
// - serdes mask nibble selects ports to enable, zero leaves a port as it was
// - new mode waits for soft reset
// - main register reads active mode
// - mac and serdes registers global, other registers per port
// - broadcast bit writes all ports at once
`timescale 1ns/100ps
`default_nettype none
`include "pmsc_map.svh"

module pmsc_dev
	import pmsc_pkg::*;
#(
	parameter int NP = 2,
	parameter int PW = 1
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	pmsc_link_if.dev lnk,
	output logic o_host_sgmii,
	output logic o_host_qsgmii,
	output logic [NP-1:0] o_host_1000x,
	output logic [NP-1:0][2:0] o_media_mode,
	output logic [NP-1:0] o_fibre_1000x,
	output logic [NP-1:0] o_aneg_en,
	output logic [NP-1:0] o_media_sds_en,
	output logic [15:0] o_sds_cfg
);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic [NP-1:0][15:0] ctrl;
		logic [NP-1:0][15:0] pend;
		logic [NP-1:0][15:0] act;
		logic [NP-1:0] bcast;
		logic [15:0] mac;
		logic [15:0] sds;
		logic [15:0] rdata;
		logic ack;
		logic [NP-1:0] med_en;
		logic [NP-1:0] fib;
		logic host_sgmii;
		logic host_qsgmii;
	} pmsc_dev_st_t;

	localparam pmsc_dev_st_t ST_RST = '{
		ctrl: {NP{`PMSC_CTRL_RST}},
		pend: {NP{`PMSC_MAIN_RST}},
		act: {NP{`PMSC_MAIN_RST}},
		bcast: '0,
		mac: `PMSC_MAC_RST,
		sds: `PMSC_SDS_RST,
		rdata: 16'h0000,
		ack: 1'b0,
		med_en: '0,
		fib: '0,
		host_sgmii: 1'b0,
		host_qsgmii: 1'b0
	};

	localparam logic [15:0] SRST_MASK = 16'h0001 << `PMSC_CTRL_SRST;

	pmsc_dev_st_t cur_ff;
	pmsc_dev_st_t nxt_ff;

	// ************************************************
	// helpers
	// ************************************************
	// serdes word of the media form: 0x8?C1 with a port mask in the ? nibble
	function automatic logic sds_is_media(input logic [15:0] w);
		sds_is_media = (w & `PMSC_SDS_MATCH) == (`PMSC_SDS_MEDIA & `PMSC_SDS_MATCH);
	endfunction

	function automatic logic [2:0] med_field(input logic [15:0] w);
		med_field = w[`PMSC_MAIN_MED_LO +: 3];
	endfunction

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		logic port_ok;
		logic bc;
		logic hit;
		nxt_ff = cur_ff;
		port_ok = 1'b0;
		bc = 1'b0;
		hit = 1'b0;
		nxt_ff.ack = 1'b0;
		// one answer per request; the cycle with ack high never starts another
		if (lnk.req && !cur_ff.ack)
		begin
			nxt_ff.ack = 1'b1;
			nxt_ff.rdata = 16'h0000;
			if (lnk.glob)
			begin
				// global page, one copy for the whole device
				if (lnk.addr == `PMSC_GREG_SDS)
				begin
					nxt_ff.rdata = cur_ff.sds;
					if (lnk.we)
					begin
						nxt_ff.sds = lnk.wdata;
						if (sds_is_media(lnk.wdata))
						begin
							for (int p = 0; p < NP; p++)
							begin
								// cleared mask bit leaves that port untouched
								if (p < 4 && lnk.wdata[`PMSC_SDS_MASK_LO + p])
								begin
									nxt_ff.med_en[p] = 1'b1;
								end
							end
						end
					end
				end
				else if (lnk.addr == `PMSC_GREG_MAC)
				begin
					nxt_ff.rdata = cur_ff.mac;
					if (lnk.we)
					begin
						nxt_ff.mac = lnk.wdata;
					end
				end
			end
			else
			begin
				port_ok = int'(lnk.port) < NP;
				if (port_ok)
				begin
					bc = cur_ff.bcast[lnk.port];
					if (lnk.addr == `PMSC_REG_CTRL)
					begin
						nxt_ff.rdata = cur_ff.ctrl[lnk.port];
					end
					else if (lnk.addr == `PMSC_REG_BCAST)
					begin
						nxt_ff.rdata = 16'(cur_ff.bcast[lnk.port]) << `PMSC_BCAST_BIT;
					end
					else if (lnk.addr == `PMSC_REG_MAIN)
					begin
						nxt_ff.rdata = cur_ff.act[lnk.port];
					end
				end
				for (int p = 0; p < NP; p++)
				begin
					hit = port_ok && lnk.we && (bc || lnk.port == PW'(p));
					if (hit)
					begin
						if (lnk.addr == `PMSC_REG_CTRL)
						begin
							// reset bit is never stored, so it reads back as zero
							nxt_ff.ctrl[p] = lnk.wdata & ~SRST_MASK;
							if (lnk.wdata[`PMSC_CTRL_SRST])
							begin
								nxt_ff.act[p] = cur_ff.pend[p];
							end
						end
						else if (lnk.addr == `PMSC_REG_BCAST)
						begin
							nxt_ff.bcast[p] = lnk.wdata[`PMSC_BCAST_BIT];
						end
						else if (lnk.addr == `PMSC_REG_MAIN)
						begin
							nxt_ff.pend[p] = lnk.wdata;
						end
					end
				end
			end
		end
		// decoded modes, registered with the rest of the state
		nxt_ff.host_sgmii = nxt_ff.mac[`PMSC_MAC_LO +: 2] == `PMSC_MAC_SGMII;
		nxt_ff.host_qsgmii = nxt_ff.mac[`PMSC_MAC_LO +: 2] == `PMSC_MAC_QSGMII;
		for (int p = 0; p < NP; p++)
		begin
			nxt_ff.fib[p] = med_field(nxt_ff.act[p]) == `PMSC_MED_1000X;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cur_ff <= ST_RST;
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign lnk.ack = cur_ff.ack;
	assign lnk.rdata = cur_ff.rdata;
	assign o_host_sgmii = cur_ff.host_sgmii;
	assign o_host_qsgmii = cur_ff.host_qsgmii;
	assign o_fibre_1000x = cur_ff.fib;
	assign o_media_sds_en = cur_ff.med_en;
	assign o_sds_cfg = cur_ff.sds;

	always_comb
	begin
		for (int p = 0; p < NP; p++)
		begin
			// host 1000x and media mode follow the active copy only, never the pending one; aneg follows the control register
			o_host_1000x[p] = cur_ff.act[p][`PMSC_MAIN_HX];
			o_media_mode[p] = med_field(cur_ff.act[p]);
			o_aneg_en[p] = cur_ff.ctrl[p][`PMSC_CTRL_ANEG];
		end
	end

endmodule

`default_nettype wire

// ==== hw/pmsc_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pmsc_map.svh"

module pmsc_ctl
	import pmsc_pkg::*;
#(
	parameter int NP = 2,
	parameter int PW = 1
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	pmsc_link_if.ctl lnk,
	input wire logic [4:0] i_av_address,
	input wire logic i_av_read,
	input wire logic i_av_write,
	input wire logic [31:0] i_av_writedata,
	input wire logic [3:0] i_av_byteenable,
	output logic [31:0] o_av_readdata,
	output logic o_av_waitrequest
);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		pmsc_hst_t st;
		pmsc_step_t step;
		logic [7:0] sport;
		pmsc_op_t op;
		logic req;
		logic [31:0] addr_w;
		logic [31:0] wdata_w;
		logic [31:0] setup_w;
		logic [15:0] rdata;
		logic done;
		logic rd_ok;
		logic [31:0] av_rd;
	} pmsc_ctl_st_t;

	pmsc_ctl_st_t cur_ff;
	pmsc_ctl_st_t nxt_ff;

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		be_merge = o;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				be_merge[8*i +: 8] = n[8*i +: 8];
			end
		end
	endfunction

	// one write of the setup sequence; one protocol for every port
	function automatic pmsc_op_t seq_op(input pmsc_step_t s, input logic [7:0] p, input logic [31:0] su);
		logic qsg;
		logic fib;
		qsg = su[`PMSC_SU_QSG];
		fib = su[`PMSC_SU_FIB];
		seq_op = '{we: 1'b1, glob: 1'b1, port: p, addr: `PMSC_GREG_MAC, data: 16'h0000};
		case (s)
			SQ_MAC:
				seq_op.data = 16'(qsg ? `PMSC_MAC_QSGMII : `PMSC_MAC_SGMII) << `PMSC_MAC_LO;
			SQ_SDS:
			begin
				seq_op.addr = `PMSC_GREG_SDS;
				seq_op.data = qsg ? `PMSC_SDS_QSGMII : `PMSC_SDS_SGMII;
			end
			SQ_MAIN:
			begin
				seq_op.glob = 1'b0;
				seq_op.addr = `PMSC_REG_MAIN;
				// host 1000x bit left clear
				seq_op.data = fib ? (16'(`PMSC_MED_1000X) << `PMSC_MAIN_MED_LO) : 16'h0000;
			end
			SQ_CTRL:
			begin
				seq_op.glob = 1'b0;
				seq_op.addr = `PMSC_REG_CTRL;
				seq_op.data = (16'h0001 << `PMSC_CTRL_SRST) | (16'(fib) << `PMSC_CTRL_ANEG);
			end
			SQ_MEDIA:
			begin
				seq_op.addr = `PMSC_GREG_SDS;
				seq_op.data = (`PMSC_SDS_MEDIA & ~`PMSC_SDS_PMASK)
					| (16'(su[`PMSC_SU_MASK_LO +: 4]) << `PMSC_SDS_MASK_LO);
			end
			default:
				seq_op.data = 16'h0000;
		endcase
	endfunction

	// ************************************************
	// next state
	// ************************************************
	logic busy;
	logic wr_stall;

	assign busy = cur_ff.st != H_IDLE;
	// launching while a link access is open would lose it, so the master waits
	assign wr_stall = i_av_write && busy && (i_av_address == `PMSC_AV_CMD || i_av_address == `PMSC_AV_SETUP);
	assign o_av_waitrequest = (i_av_read && !cur_ff.rd_ok) || wr_stall;

	always_comb
	begin
		pmsc_step_t ns;
		nxt_ff = cur_ff;
		ns = SQ_NONE;
		nxt_ff.rd_ok = i_av_read && !cur_ff.rd_ok;
		if (i_av_read && !cur_ff.rd_ok)
		begin
			nxt_ff.av_rd = 32'h00000000;
			if (i_av_address == `PMSC_AV_ADDR)
			begin
				nxt_ff.av_rd = cur_ff.addr_w;
			end
			else if (i_av_address == `PMSC_AV_WDATA)
			begin
				nxt_ff.av_rd = cur_ff.wdata_w;
			end
			else if (i_av_address == `PMSC_AV_STAT)
			begin
				nxt_ff.av_rd = {cur_ff.rdata, 14'h0000, cur_ff.done, busy};
			end
			else if (i_av_address == `PMSC_AV_SETUP)
			begin
				nxt_ff.av_rd = cur_ff.setup_w;
			end
		end
		if (i_av_write && !wr_stall)
		begin
			if (i_av_address == `PMSC_AV_ADDR)
			begin
				nxt_ff.addr_w = be_merge(cur_ff.addr_w, i_av_writedata, i_av_byteenable);
			end
			else if (i_av_address == `PMSC_AV_WDATA)
			begin
				nxt_ff.wdata_w = be_merge(cur_ff.wdata_w, i_av_writedata, i_av_byteenable);
			end
			else if (i_av_address == `PMSC_AV_CMD)
			begin
				if (i_av_byteenable[0] && (i_av_writedata[0] || i_av_writedata[1]))
				begin
					nxt_ff.st = H_REQ;
					nxt_ff.req = 1'b1;
					nxt_ff.step = SQ_NONE;
					nxt_ff.done = 1'b0;
					nxt_ff.op = '{we: i_av_writedata[0], glob: cur_ff.addr_w[8], port: cur_ff.addr_w[23:16],
						addr: cur_ff.addr_w[4:0], data: cur_ff.wdata_w[15:0]};
				end
			end
			else if (i_av_address == `PMSC_AV_SETUP)
			begin
				nxt_ff.setup_w = be_merge(cur_ff.setup_w, i_av_writedata, i_av_byteenable);
				nxt_ff.setup_w[`PMSC_SU_GO] = 1'b0;
				if (i_av_byteenable[3] && i_av_writedata[`PMSC_SU_GO])
				begin
					nxt_ff.st = H_REQ;
					nxt_ff.req = 1'b1;
					nxt_ff.step = SQ_MAC;
					nxt_ff.sport = 8'h00;
					nxt_ff.done = 1'b0;
					nxt_ff.op = seq_op(SQ_MAC, 8'h00, nxt_ff.setup_w);
				end
			end
		end
		case (cur_ff.st)
			H_REQ:
			begin
				if (lnk.ack)
				begin
					if (!cur_ff.op.we)
					begin
						nxt_ff.rdata = lnk.rdata;
					end
					case (cur_ff.step)
						SQ_MAC:
							ns = SQ_SDS;
						SQ_SDS:
							ns = SQ_MAIN;
						SQ_MAIN:
							ns = SQ_CTRL;
						SQ_CTRL:
						begin
							if (32'(cur_ff.sport) < NP - 1)
							begin
								ns = SQ_MAIN;
								nxt_ff.sport = cur_ff.sport + 8'h01;
							end
							else if (cur_ff.setup_w[`PMSC_SU_FIB])
							begin
								ns = SQ_MEDIA;
							end
						end
						default:
							ns = SQ_NONE;
					endcase
					nxt_ff.step = ns;
					if (ns == SQ_NONE)
					begin
						nxt_ff.st = H_IDLE;
						nxt_ff.req = 1'b0;
						nxt_ff.done = 1'b1;
					end
					else
					begin
						nxt_ff.op = seq_op(ns, nxt_ff.sport, cur_ff.setup_w);
					end
				end
			end
			default:
				// a launch taken above in this cycle must keep its request
				nxt_ff.req = nxt_ff.st == H_REQ;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cur_ff <= '{st: H_IDLE, step: SQ_NONE, default: '0};
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	assign lnk.req = cur_ff.req;
	assign lnk.we = cur_ff.op.we;
	assign lnk.glob = cur_ff.op.glob;
	assign lnk.port = cur_ff.op.port[PW-1:0];
	assign lnk.addr = cur_ff.op.addr;
	assign lnk.wdata = cur_ff.op.data;
	assign o_av_readdata = cur_ff.av_rd;

endmodule

`default_nettype wire

// ==== testbench/pmsc_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

module pmsc_checker
#(
	parameter int PW = 1
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic req,
	input wire logic we,
	input wire logic glob,
	input wire logic [PW-1:0] port,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack
);
	logic take;

	// a request counts only while no answer is standing
	assign take = req && !ack;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	// ************************************************
	// link handshake
	// ************************************************
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack held longer than one cycle");
	a_ack_cause: assert property (ack |-> $past(take))
		else $error("ack without a taken request");
	a_req_answer: assert property (take |=> ack)
		else $error("request not answered in the next cycle");
	a_req_hold: assert property (take |=> req && $stable(we) && $stable(glob) && $stable(port) && $stable(addr)
		&& $stable(wdata))
		else $error("request changed before its answer");
	a_rdata_hold: assert property (!take |=> $stable(rdata))
		else $error("read data moved without a new request");

	// ************************************************
	// configuration words sent by the controller
	// ************************************************
	a_mac_word: assert property (take && we && glob && addr == 5'h13 |-> wdata[15:14] inside {2'h0, 2'h1})
		else $error("host protocol word neither sgmii nor qsgmii");
	a_main_host: assert property (take && we && !glob && addr == 5'h17 |-> !wdata[12])
		else $error("main mode write sets the 1000x host bit");
	a_sds_word: assert property (take && we && glob && addr == 5'h12 |-> wdata == 16'h80F0
		|| wdata == 16'h80E0 || (wdata & 16'hF0FF) == 16'h80C1)
		else $error("serdes word outside the allowed set");
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [4:0] av_address = 5'h00;
	logic av_read = 1'b0;
	logic av_write = 1'b0;
	logic [31:0] av_writedata = 32'h0;
	logic [3:0] av_byteenable = 4'hF;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	logic o_host_sgmii;
	logic o_host_qsgmii;
	logic [1:0] o_host_1000x;
	logic [1:0][2:0] o_media_mode;
	logic [1:0] o_fibre_1000x;
	logic [1:0] o_aneg_en;
	logic [1:0] o_media_sds_en;
	logic [15:0] o_sds_cfg;
	int fails = 0;
	int total_checks = 0;
	logic [5:0] cases [4] = '{6'h11, 6'h32, 6'h00, 6'h20};
	logic [5:0] c;
	logic [15:0] q;
	logic [15:0] sds;
	logic [1:0] en = 2'b00;
	logic [31:0] s;

	always #2.5 i_clk = ~i_clk;

	pmsc_link_if lnk_i ();

	pmsc_dev #(.NP(2), .PW(1)) pmsc_dev_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk_i),
		.o_host_sgmii(o_host_sgmii), .o_host_qsgmii(o_host_qsgmii), .o_host_1000x(o_host_1000x),
		.o_media_mode(o_media_mode), .o_fibre_1000x(o_fibre_1000x), .o_aneg_en(o_aneg_en),
		.o_media_sds_en(o_media_sds_en), .o_sds_cfg(o_sds_cfg));

	pmsc_ctl #(.NP(2), .PW(1)) pmsc_ctl_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk_i),
		.i_av_address(av_address), .i_av_read(av_read), .i_av_write(av_write), .i_av_writedata(av_writedata),
		.i_av_byteenable(av_byteenable), .o_av_readdata(av_readdata), .o_av_waitrequest(av_waitrequest));

	pmsc_checker pmsc_checker_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .req(lnk_i.req), .we(lnk_i.we),
		.glob(lnk_i.glob), .port(lnk_i.port), .addr(lnk_i.addr), .wdata(lnk_i.wdata), .rdata(lnk_i.rdata),
		.ack(lnk_i.ack));

	// ************************************************
	// check and bus tasks
	// ************************************************
	task automatic complete_run();
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check_w(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one avalon cycle; the extra edge keeps two requests from sharing a time step
	task automatic av_cycle(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		av_address <= a;
		av_writedata <= d;
		av_write <= wr;
		av_read <= !wr;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (av_waitrequest !== 1'b0 && n < 100);
		r = av_readdata;
		av_write <= 1'b0;
		av_read <= 1'b0;
		if (n >= 100)
		begin
			fails++;
			complete_run();
		end
		@(posedge i_clk);
	endtask

	task automatic wait_idle();
		logic [31:0] r;
		int n;
		n = 0;
		r = 32'h1;
		while (r[0] !== 1'b0 && n < 50)
		begin
			av_cycle(1'b0, 5'h0C, 32'h0, r);
			n++;
		end
		if (r[0] !== 1'b0)
		begin
			fails++;
			complete_run();
		end
	endtask

	task automatic dev_op(input logic wr, input logic g, input logic [4:0] r, input logic p, input logic [15:0] d,
		output logic [15:0] rq);
		logic [31:0] t;
		av_cycle(1'b1, 5'h00, {8'h00, 7'h00, p, 7'h00, g, 3'h0, r}, t);
		av_cycle(1'b1, 5'h04, {16'h0000, d}, t);
		av_cycle(1'b1, 5'h08, {30'h0, !wr, wr}, t);
		wait_idle();
		av_cycle(1'b0, 5'h0C, 32'h0, t);
		rq = t[31:16];
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		av_cycle(1'b0, 5'h0C, 32'h0, s);
		check_w("status after reset", 16'h0, s[15:0]);
		check_w("serdes after reset", 16'h0, o_sds_cfg);
		check_w("host sgmii after reset", 16'h1, 16'(o_host_sgmii));
		for (int i = 0; i < 4; i++)
		begin
			c = cases[i];
			av_cycle(1'b1, 5'h10, {1'b1, 19'h0, c[3:0], 6'h0, c[4], c[5]}, s);
			wait_idle();
			sds = c[4] ? (16'h80C1 | {4'h0, c[3:0], 8'h00}) : (c[5] ? 16'h80E0 : 16'h80F0);
			en = en | (c[4] ? c[1:0] : 2'b00);
			check_w("serdes word", sds, o_sds_cfg);
			check_w("serdes port enable", 16'(en), 16'(o_media_sds_en));
			check_w("host sgmii", 16'(!c[5]), 16'(o_host_sgmii));
			check_w("host qsgmii", 16'(c[5]), 16'(o_host_qsgmii));
			check_w("fibre", c[4] ? 16'h3 : 16'h0, 16'(o_fibre_1000x));
			check_w("media mode", c[4] ? 16'h12 : 16'h0, 16'(o_media_mode));
			check_w("aneg", c[4] ? 16'h3 : 16'h0, 16'(o_aneg_en));
			check_w("host 1000x", 16'h0, 16'(o_host_1000x));
		end
		dev_op(1'b1, 1'b0, 5'h17, 1'b0, 16'h0200, q);
		check_w("fibre before soft reset", 16'h0, 16'(o_fibre_1000x));
		dev_op(1'b0, 1'b0, 5'h17, 1'b0, 16'h0, q);
		check_w("main read pending", 16'h0, q);
		dev_op(1'b1, 1'b0, 5'h00, 1'b0, 16'h8000, q);
		check_w("fibre after soft reset", 16'h1, 16'(o_fibre_1000x));
		dev_op(1'b0, 1'b0, 5'h17, 1'b0, 16'h0, q);
		check_w("main read active", 16'h0200, q);
		dev_op(1'b1, 1'b0, 5'h00, 1'b1, 16'h1000, q);
		check_w("aneg one port", 16'h2, 16'(o_aneg_en));
		dev_op(1'b0, 1'b0, 5'h00, 1'b1, 16'h0, q);
		check_w("control read", 16'h1000, q);
		dev_op(1'b1, 1'b0, 5'h16, 1'b0, 16'h0001, q);
		dev_op(1'b1, 1'b0, 5'h17, 1'b0, 16'h0200, q);
		dev_op(1'b1, 1'b0, 5'h00, 1'b0, 16'h8000, q);
		check_w("broadcast fibre", 16'h3, 16'(o_fibre_1000x));
		check_w("broadcast aneg", 16'h0, 16'(o_aneg_en));
		dev_op(1'b1, 1'b0, 5'h16, 1'b0, 16'h0, q);
		dev_op(1'b1, 1'b0, 5'h17, 1'b1, 16'h0, q);
		dev_op(1'b1, 1'b0, 5'h00, 1'b1, 16'h8000, q);
		check_w("single port fibre", 16'h1, 16'(o_fibre_1000x));
		dev_op(1'b1, 1'b1, 5'h13, 1'b0, 16'h0000, q);
		check_w("global sgmii", 16'h1, 16'(o_host_sgmii));
		check_w("global qsgmii", 16'h0, 16'(o_host_qsgmii));
		dev_op(1'b0, 1'b0, 5'h05, 1'b0, 16'h0, q);
		check_w("unmapped device read", 16'h0, q);
		av_cycle(1'b0, 5'h14, 32'h0, s);
		check_w("unmapped bus read", 16'h0, s[31:16] | s[15:0]);
		av_byteenable <= 4'h3;
		av_cycle(1'b1, 5'h04, 32'hABCD1234, s);
		av_cycle(1'b0, 5'h04, 32'h0, s);
		check_w("wdata low bytes", 16'h1234, s[15:0]);
		check_w("wdata high bytes kept", 16'h0000, s[31:16]);
		av_byteenable <= 4'hE;
		av_cycle(1'b1, 5'h08, 32'h00000001, s);
		av_cycle(1'b0, 5'h0C, 32'h0, s);
		check_w("command without byte 0", 16'h0, 16'(s[0]));
		av_byteenable <= 4'hF;
		complete_run();
	end
endmodule

`default_nettype wire
